// ===== rtl/sertx_baud.sv
`default_nettype none

module sertx_baud
   import sertx_pkg::*;
#(
   parameter logic [15:0] DIV_LO = sertx_pkg::DIV_LOW,
   parameter logic [15:0] DIV_HI = sertx_pkg::DIV_HIGH
) (
   input wire logic clk,
   input wire logic rst_n,
   sertx_if.baud    lnk
);
   typedef struct packed {
      logic [15:0] cnt;
      logic        tick;
   } sertx_baud_t;

   sertx_baud_t r;
   sertx_baud_t n;
   logic [15:0] div;

   always_comb begin
      n      = r;
      n.tick = 1'b0;
      div    = (lnk.hibaud && !lnk.sync) ? DIV_HI : DIV_LO; // RQ7
      if (!lnk.run) begin
         n.cnt = 16'h0000;
      end else if (r.cnt == 16'h0000) begin
         n.cnt  = div - 16'h0001;
         n.tick = 1'b1;
      end else begin
         n.cnt = r.cnt - 16'h0001;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end

   assign lnk.tick = r.tick;

   AST_SYNC_RATE: assert property (@(posedge clk) disable iff (!rst_n) // RQ7
      (lnk.run && lnk.sync && r.cnt == 16'h0000) |=> r.cnt == DIV_LO - 16'h0001)
      else $error("sync rate not slow divisor");
   AST_HIGH_RATE: assert property (@(posedge clk) disable iff (!rst_n) // RQ7
      (lnk.run && !lnk.sync && lnk.hibaud && r.cnt == 16'h0000) |=> r.cnt == DIV_HI - 16'h0001)
      else $error("high rate divisor wrong");
endmodule

`default_nettype wire

// ===== rtl/sertx_edge.sv
`default_nettype none

module sertx_edge
   import sertx_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   sertx_if.ckedge  lnk
);
   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
      logic fall;
   } sertx_edge_t;

   sertx_edge_t r;
   sertx_edge_t n;

   // Two-stage synchroniser, then falling edge
   always_comb begin
      n.s1   = lnk.ck_in;
      n.s2   = r.s1;
      n.s3   = r.s2;
      n.fall = r.s3 & ~r.s2;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end

   assign lnk.ck_fall = r.fall;
endmodule

`default_nettype wire

// ===== rtl/sertx_if.sv
`default_nettype none

interface sertx_if;
   logic run;
   logic hibaud;
   logic sync;
   logic tick;
   logic ck_in;
   logic ck_fall;

   modport core (output run, hibaud, sync, ck_in, input tick, ck_fall);
   modport baud (input run, hibaud, sync, output tick);
   modport ckedge (input ck_in, output ck_fall);
endinterface

`default_nettype wire

// ===== rtl/sertx_pkg.sv
// Notes on behaviour
// [RQ1] Synchronous mode: clock source bit set drives the shift clock, clear follows external clock.
// [RQ2] Asynchronous mode ignores the clock source bit.
// [RQ3] Nine-bit select set sends 9-bit characters, clear sends 8-bit.
// [RQ4] Transmitter on bit enables the transmitter; clearing it stops and idles it.
// [RQ5] Link mode bit set selects synchronous mode, clear selects asynchronous.
// [RQ6] Bit 3 is unimplemented: reads zero, writes ignored.
// [RQ7] High baud bit picks fast or slow rate in asynchronous mode only.
// [RQ8] Empty flag reads one while the shift register is idle, zero while shifting.
// [RQ9] Bit 0 is the ninth transmit bit, sent in 9-bit mode.
// [RQ10] Synchronous mode: any receive enable overrides the transmitter on bit.
// [RQ11] Control bits reset to zero; empty flag resets to one.
`default_nettype none

package sertx_pkg;

   // ==========================================
   // Register map
   localparam int         ADDR_W      = 3;
   localparam logic [2:0] OFS_CTRL    = 3'h0;
   localparam logic [2:0] OFS_DATA    = 3'h1;
   localparam logic [2:0] OFS_RXCTL   = 3'h2;
   localparam logic [2:0] OFS_STAT    = 3'h3;
   localparam logic [2:0] OFS_MASK    = 3'h4;

   // ==========================================
   // Control register fields
   localparam int         B_CLKSRC    = 7;
   localparam int         B_NINE      = 6;
   localparam int         B_TXON      = 5;
   localparam int         B_SYNC      = 4;
   localparam int         B_UNIMP     = 3;
   localparam int         B_HIBAUD    = 2;
   localparam int         B_EMPTY     = 1;
   localparam int         B_NINTH     = 0;
   localparam logic [7:0] CTRL_RST    = 8'h02;
   localparam logic [7:0] CTRL_WMASK  = 8'hF5;

   localparam int         B_RX_SINGLE = 0;
   localparam int         B_RX_CONT   = 1;
   localparam int         EV_DONE     = 0;
   localparam int         EV_LOAD     = 1;

   // ==========================================
   // Timing
   localparam int          CLK_PERIOD_NS     = 4;
   localparam int          BIT_TIME_HIGH_NS  = 1000;
   localparam int          BIT_TIME_LOW_NS   = 4000;
   localparam logic [15:0] DIV_HIGH = 16'(BIT_TIME_HIGH_NS / CLK_PERIOD_NS);
   localparam logic [15:0] DIV_LOW  = 16'(BIT_TIME_LOW_NS / CLK_PERIOD_NS);
   localparam logic [3:0]  BITS8    = 4'h8;
   localparam logic [3:0]  BITS9    = 4'h9;

   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_START = 2'b01,
      ST_DATA  = 2'b10,
      ST_STOP  = 2'b11
   } sertx_state_t;

endpackage

`default_nettype wire

// ===== rtl/sertx_top.sv
`default_nettype none

module sertx_top
   import sertx_pkg::*;
(
   input  wire logic                         CLK,
   input  wire logic                         RST_N,
   input  wire logic [sertx_pkg::ADDR_W-1:0] ADDR,
   input  wire logic [7:0]                   WDATA,
   input  wire logic                         WR,
   input  wire logic                         RD,
   output logic      [7:0]                   RDATA,
   output logic                              IRQ,
   output logic                              TX_LINE,
   output logic                              CK_OUT,
   output logic                              CK_OE_N,
   input  wire logic                         CK_IN
);
   // ==========================================
   // State
   typedef struct packed {
      logic [7:0]   ctrl;
      logic [1:0]   rxctl;
      logic [1:0]   stat;
      logic [1:0]   mask;
      logic [7:0]   rdata;
      logic         irq;
      sertx_state_t st;
      logic [8:0]   sh;
      logic [3:0]   cnt;
      logic         phase;
      logic         line;
      logic         ck;
      logic         ck_oe_n;
   } sertx_core_t;

   sertx_core_t r;
   sertx_core_t n;

   logic sync;
   logic master;
   logic rx_over;
   logic on;
   logic nine;
   logic strobe;
   logic load;
   logic ev_done;
   logic ev_load;

   sertx_if lnk ();

   sertx_baud u_baud (
      .clk   (CLK),
      .rst_n (RST_N),
      .lnk   (lnk.baud)
   );

   sertx_edge u_edge (
      .clk   (CLK),
      .rst_n (RST_N),
      .lnk   (lnk.ckedge)
   );

   // ==========================================
   // Mode decode
   always_comb begin
      sync    = r.ctrl[B_SYNC]; // RQ5
      master  = sync & r.ctrl[B_CLKSRC]; // RQ1 RQ2
      rx_over = sync & (r.rxctl[B_RX_SINGLE] | r.rxctl[B_RX_CONT]); // RQ10
      on      = r.ctrl[B_TXON] & ~rx_over; // RQ4
      nine    = r.ctrl[B_NINE];
      strobe  = (sync && !master) ? lnk.ck_fall : lnk.tick;
      load    = WR && ADDR == OFS_DATA && on && r.st == ST_IDLE;
   end

   assign lnk.run    = on;
   assign lnk.hibaud = r.ctrl[B_HIBAUD];
   assign lnk.sync   = sync;
   assign lnk.ck_in  = CK_IN;

   // ==========================================
   // Next state
   always_comb begin
      n       = r;
      ev_done = 1'b0;
      ev_load = 1'b0;

      // Register writes
      if (WR) begin
         case (ADDR)
            OFS_CTRL: begin
               n.ctrl = (WDATA & CTRL_WMASK) | (r.ctrl & ~CTRL_WMASK); // RQ6
            end
            OFS_RXCTL: begin
               n.rxctl = WDATA[1:0];
            end
            OFS_MASK: begin
               n.mask = WDATA[1:0];
            end
            default: begin
            end
         endcase
      end

      // Shifter
      if (!on) begin
         n.st    = ST_IDLE; // RQ4 RQ10
         n.line  = 1'b1;
         n.ck    = 1'b0;
         n.phase = 1'b0;
      end else if (load) begin
         ev_load = 1'b1;
         n.phase = 1'b0;
         n.ck    = 1'b0;
         if (sync) begin
            n.st   = ST_DATA; // RQ5
            n.line = WDATA[0];
            n.sh   = {1'b0, r.ctrl[B_NINTH], WDATA[7:1]}; // RQ9
            n.cnt  = (nine ? BITS9 : BITS8) - 4'h1; // RQ3
         end else begin
            n.st   = ST_START;
            n.line = 1'b0;
            n.sh   = {r.ctrl[B_NINTH], WDATA}; // RQ9
            n.cnt  = nine ? BITS9 : BITS8; // RQ3
         end
      end else begin
         unique case (r.st)
            ST_IDLE: begin
            end
            ST_START: begin
               if (strobe) begin
                  n.st   = ST_DATA;
                  n.line = r.sh[0];
                  n.sh   = r.sh >> 1;
                  n.cnt  = r.cnt - 4'h1;
               end
            end
            ST_DATA: begin
               if (strobe) begin
                  if (master && !r.phase) begin
                     n.phase = 1'b1; // RQ1
                     n.ck    = 1'b1;
                  end else begin
                     n.phase = 1'b0;
                     n.ck    = 1'b0;
                     if (r.cnt == 4'h0) begin
                        if (sync) begin
                           n.st    = ST_IDLE;
                           ev_done = 1'b1;
                        end else begin
                           n.st   = ST_STOP;
                           n.line = 1'b1;
                        end
                     end else begin
                        n.line = r.sh[0];
                        n.sh   = r.sh >> 1;
                        n.cnt  = r.cnt - 4'h1;
                     end
                  end
               end
            end
            ST_STOP: begin
               if (strobe) begin
                  n.st    = ST_IDLE;
                  ev_done = 1'b1;
               end
            end
         endcase
      end

      // Shift clock pin rests low unless master
      if (!master) begin
         n.ck = 1'b0; // RQ2
      end

      n.ctrl[B_EMPTY] = (n.st == ST_IDLE); // RQ8
      n.ck_oe_n       = ~master; // RQ1 RQ2

      // Sticky events; set wins over read clear
      if (RD && ADDR == OFS_STAT) begin
         n.stat = 2'b00;
      end
      n.stat[EV_DONE] = n.stat[EV_DONE] | ev_done;
      n.stat[EV_LOAD] = n.stat[EV_LOAD] | ev_load;
      n.irq           = |(n.stat & n.mask);

      // Read data stands one cycle only
      n.rdata = 8'h00;
      if (RD) begin
         case (ADDR)
            OFS_CTRL: begin
               n.rdata = r.ctrl; // RQ6 RQ8
            end
            OFS_RXCTL: begin
               n.rdata = {6'h00, r.rxctl};
            end
            OFS_STAT: begin
               n.rdata = {6'h00, r.stat};
            end
            OFS_MASK: begin
               n.rdata = {6'h00, r.mask};
            end
            default: begin
            end
         endcase
      end
   end

   // ==========================================
   // Registers
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         r         <= '0;
         r.ctrl    <= CTRL_RST; // RQ11
         r.line    <= 1'b1;
         r.ck_oe_n <= 1'b1;
      end else begin
         r <= n;
      end
   end

   assign RDATA   = r.rdata;
   assign IRQ     = r.irq;
   assign TX_LINE = r.line;
   assign CK_OUT  = r.ck;
   assign CK_OE_N = r.ck_oe_n;

   // ==========================================
   // Checks
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (!RST_N);

   sequence s_load_async9;
      load && nine && !sync;
   endsequence

   sequence s_load_async8;
      load && !nine && !sync;
   endsequence

   sequence s_ctrl_read;
      RD && ADDR == OFS_CTRL;
   endsequence

   AST_MASTER_DRIVES: assert property ((sync && r.ctrl[B_CLKSRC]) |=> !CK_OE_N) // RQ1
      else $error("master clock not driven");
   AST_SLAVE_RELEASES: assert property ((sync && !r.ctrl[B_CLKSRC]) |=> CK_OE_N) // RQ1
      else $error("slave clock driven");
   AST_ASYNC_IGNORES_SRC: assert property (!sync |=> CK_OE_N && !CK_OUT) // RQ2
      else $error("async clock pin active");
   AST_NINE_COUNT: assert property (s_load_async9 |=> r.cnt == 4'h9 && r.st == ST_START) // RQ3
      else $error("nine-bit count wrong");
   AST_EIGHT_COUNT: assert property (s_load_async8 |=> r.cnt == 4'h8 && !TX_LINE) // RQ3
      else $error("eight-bit count wrong");
   AST_OFF_IDLE: assert property (!on |=> r.st == ST_IDLE && TX_LINE) // RQ4
      else $error("transmitter running while off");
   AST_SYNC_NO_START: assert property ((load && sync) |=> r.st == ST_DATA) // RQ5
      else $error("sync load framed");
   AST_UNIMP_ZERO: assert property (s_ctrl_read |=> RDATA[B_UNIMP] == 1'b0) // RQ6
      else $error("unimplemented bit read one");
   AST_EMPTY_READ: assert property (s_ctrl_read |=> RDATA[B_EMPTY] == ($past(r.st) == ST_IDLE)) // RQ8
      else $error("empty flag wrong");
   AST_EMPTY_FALLS: assert property (load |=> !r.ctrl[B_EMPTY]) // RQ8
      else $error("empty flag stays set");
   AST_NINTH_BIT: assert property (s_load_async9 |=> r.sh[8] == $past(r.ctrl[B_NINTH])) // RQ9
      else $error("ninth bit not captured");
   AST_RX_OVERRIDE: assert property ((sync && r.rxctl != 2'b00) |=> r.st == ST_IDLE) // RQ10
      else $error("receive does not override");
   AST_DONE_STICKY: assert property ((r.st == ST_STOP && strobe && on) |=> r.stat[EV_DONE] && (IRQ || !r.mask[EV_DONE]))
      else $error("done event lost");
endmodule

`default_nettype wire

// ===== sim/serial_tx_status_control_tb_top.sv
`default_nettype none

module serial_tx_status_control_tb_top
   import sertx_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;

   typedef struct packed {
      logic [2:0] a;
      logic [7:0] d;
      logic [7:0] e;
   } sertx_row_t;

   localparam sertx_row_t ROWS [6] = '{
      '{OFS_CTRL, 8'hFF, 8'hF7}, '{OFS_CTRL, 8'h08, 8'h02}, '{OFS_CTRL, 8'h01, 8'h03},
      '{OFS_MASK, 8'h03, 8'h03}, '{3'h5, 8'hFF, 8'h00}, '{OFS_MASK, 8'h01, 8'h01}};

   logic       CLK   = 1'b0;
   logic       RST_N = 1'b0;
   logic       WR    = 1'b0;
   logic       RD    = 1'b0;
   logic [2:0] ADDR  = 3'h0;
   logic [7:0] WDATA = 8'h00;
   logic       clr   = 1'b0;
   logic       start = 1'b0;
   logic [3:0] n_clk = 4'h0;
   logic [15:0] bit_len = 16'h0000;
   logic [7:0] v;
   int         n_mismatch      = 0;
   int         samples_checked = 0;
   int         cyc             = 0;
   wire logic [7:0] RDATA;
   wire logic [8:0] rx_bits;
   wire logic       IRQ, TX_LINE, CK_OUT, CK_OE_N, CK_IN;

   sertx_top uut (.CLK(CLK), .RST_N(RST_N), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
      .RDATA(RDATA), .IRQ(IRQ), .TX_LINE(TX_LINE), .CK_OUT(CK_OUT), .CK_OE_N(CK_OE_N), .CK_IN(CK_IN));

   sertx_peer peer (.clk(CLK), .tx_line(TX_LINE), .ck_out(CK_OUT), .ck_oe_n(CK_OE_N), .clr(clr),
      .n_clk(n_clk), .bit_len(bit_len), .start(start), .ck_in(CK_IN), .rx_bits(rx_bits));

   always #2 CLK = ~CLK;

   // ==========================================
   // Checks and bus cycles
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask

   task automatic chk_byte(input logic [8:0] g, input logic [8:0] e);
      samples_checked++;
      if (g !== e) begin
         n_mismatch++;
         $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask

   task automatic chk_range(input int g, input int lo, input int hi);
      samples_checked++;
      if (g < lo || g > hi) begin
         n_mismatch++;
         $display("mismatch t=%0t got=%h exp=%h..%h", $time, g, lo, hi);
      end
   endtask

   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge CLK);
      ADDR  <= a;
      WDATA <= d;
      WR    <= 1'b1;
      @(posedge CLK);
      WR <= 1'b0;
   endtask

   task automatic rd(input logic [2:0] a, output logic [7:0] q);
      @(posedge CLK);
      ADDR <= a;
      RD   <= 1'b1;
      @(posedge CLK);
      RD <= 1'b0;
      @(negedge CLK);
      q = RDATA;
   endtask

   task automatic frame(input logic [7:0] c, input logic [7:0] d, input logic [3:0] n, input logic [15:0] bl,
                        input int lo, input int hi, input logic [8:0] e, input logic oe);
      int k;
      k = 0;
      @(posedge CLK);
      clr     <= 1'b1;
      n_clk   <= n;
      bit_len <= bl;
      @(posedge CLK);
      clr <= 1'b0;
      // Off then on restarts the bit timer, so the start bit is whole
      wr(OFS_CTRL, c & 8'hDF);
      wr(OFS_CTRL, c);
      wr(OFS_DATA, d);
      rd(OFS_CTRL, v);
      chk_byte(v, c & 8'hF5);
      if (n != 4'h0 && bl == 16'h0000) begin
         @(posedge CLK);
         start <= 1'b1;
         @(posedge CLK);
         start <= 1'b0;
      end
      while (IRQ !== 1'b1 && k < 20000) begin
         @(posedge CLK);
         k++;
      end
      chk_range(k, lo, hi);
      rd(OFS_STAT, v);
      chk_byte(v, 8'h03);
      chk_byte(IRQ, 1'b0);
      chk_byte(rx_bits, e);
      chk_byte(CK_OE_N, oe);
      $display("frame %h done", c);
   endtask

   always @(posedge CLK) begin
      cyc++;
      if (cyc == 60000) begin
         n_mismatch++;
         report_and_stop;
      end
   end

   // ==========================================
   // Main sequence
   initial begin
      repeat (20) @(posedge CLK);
      RST_N <= 1'b1;
      @(negedge CLK);
      chk_byte(TX_LINE, 1'b1);
      chk_byte(CK_OE_N, 1'b1);
      rd(OFS_CTRL, v);
      chk_byte(v, 8'h02);
      $display("reset test done");
      foreach (ROWS[i]) begin
         wr(ROWS[i].a, ROWS[i].d);
         rd(ROWS[i].a, v);
         chk_byte(v, ROWS[i].e);
      end
      $display("register rows done");
      frame(8'h20, 8'hA5, 4'h8, DIV_LOW, 9990, 10010, {8'hA5, 1'b0}, 1'b1);
      frame(8'hE5, 8'h3C, 4'h9, DIV_HIGH, 2740, 2760, {1'b1, 8'h3C}, 1'b1);
      frame(8'hB4, 8'hC3, 4'h0, 16'h0000, 15990, 16010, {8'hC3, 1'b0}, 1'b0);
      frame(8'h71, 8'h5A, 4'h9, 16'h0000, 270, 300, {1'b1, 8'h5A}, 1'b1);
      // Receive enable blocks the load
      wr(OFS_RXCTL, 8'h01);
      wr(OFS_CTRL, 8'hB0);
      wr(OFS_DATA, 8'hFF);
      rd(OFS_CTRL, v);
      chk_byte(v, 8'hB2);
      rd(OFS_STAT, v);
      chk_byte(v, 8'h00);
      wr(OFS_RXCTL, 8'h02);
      wr(OFS_DATA, 8'hFF);
      rd(OFS_STAT, v);
      chk_byte(v, 8'h00);
      wr(OFS_RXCTL, 8'h00);
      $display("override test done");
      // Switching off mid-frame idles the line
      wr(OFS_CTRL, 8'h20);
      wr(OFS_DATA, 8'h00);
      repeat (50) @(posedge CLK);
      wr(OFS_CTRL, 8'h00);
      @(posedge CLK);
      @(negedge CLK);
      chk_byte(TX_LINE, 1'b1);
      rd(OFS_CTRL, v);
      chk_byte(v, 8'h02);
      rd(OFS_STAT, v);
      chk_byte(v, 8'h02);
      $display("abort test done");
      // Reset in mid-frame
      wr(OFS_CTRL, 8'h20);
      wr(OFS_DATA, 8'h00);
      repeat (10) @(posedge CLK);
      RST_N <= 1'b0;
      @(negedge CLK);
      chk_byte(TX_LINE, 1'b1);
      chk_byte(IRQ, 1'b0);
      repeat (2) @(posedge CLK);
      RST_N <= 1'b1;
      rd(OFS_CTRL, v);
      chk_byte(v, 8'h02);
      rd(OFS_STAT, v);
      chk_byte(v, 8'h00);
      $display("midrun reset test done");
      report_and_stop;
   end
endmodule

`default_nettype wire

// ===== sim/sertx_peer.sv
`default_nettype none

module sertx_peer
   import sertx_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        tx_line,
   input  wire logic        ck_out,
   input  wire logic        ck_oe_n,
   input  wire logic        clr,
   input  wire logic [3:0]  n_clk,
   input  wire logic [15:0] bit_len,
   input  wire logic        start,
   output logic             ck_in,
   output logic      [8:0]  rx_bits
);
   timeunit 1ns;
   timeprecision 100ps;

   // ==========================================
   // Far-side shift clock and sampler
   logic [4:0] ph;
   logic [3:0] left;
   logic       ck_d;
   wire logic  ck;
   logic [15:0] a_cnt;
   logic [3:0]  a_left;
   logic        a_busy;
   logic        line_d;

   // Master clock when design drives it, else ours
   assign ck = ck_oe_n ? ck_in : ck_out;

   initial begin
      ck_in   = 1'b0;
      ph      = 5'h00;
      left    = 4'h0;
      ck_d    = 1'b0;
      rx_bits = 9'h000;
      a_cnt   = 16'h0000;
      a_left  = 4'h0;
      a_busy  = 1'b0;
      line_d  = 1'b1;
   end

   always @(posedge clk) begin
      ck_d <= ck;
      if (clr) begin
         rx_bits <= 9'h000;
      end else if (ck && !ck_d) begin
         rx_bits <= {tx_line, rx_bits[8:1]};
      end else if (a_busy && a_cnt == 16'h0000) begin
         rx_bits <= {tx_line, rx_bits[8:1]};
      end
      // Async sampler: mid-bit, timed from the start edge
      line_d <= tx_line;
      if (clr || bit_len == 16'h0000) begin
         a_busy <= 1'b0;
      end else if (!a_busy) begin
         if (line_d && !tx_line) begin
            a_busy <= 1'b1;
            a_cnt  <= bit_len + (bit_len >> 1);
            a_left <= n_clk;
         end
      end else if (a_cnt == 16'h0000) begin
         a_cnt  <= bit_len - 16'h0001;
         a_left <= a_left - 4'h1;
         a_busy <= (a_left != 4'h1);
      end else begin
         a_cnt <= a_cnt - 16'h0001;
      end
      // Slave clock idles low between frames
      if (start) begin
         left <= n_clk;
         ph   <= 5'h00;
      end else if (left != 4'h0) begin
         ph <= ph + 5'h01;
         if (ph == 5'h0F || ph == 5'h1F) begin
            ck_in <= ~ck_in;
         end
         if (ph == 5'h1F) begin
            left <= left - 4'h1;
         end
      end
   end
endmodule

`default_nettype wire
